// ---- logic/sed_pkg.sv ----
package sed_pkg;

	// ------------------------------------------------------------
	// sizes and reset values
	// ------------------------------------------------------------
	localparam int        SED_DATA_W      = 8;
	localparam int        SED_PTR_W       = 3;
	localparam int        SED_SYNC_STAGES = 2;
	localparam logic      SED_EN_RST      = 1'b0;
	localparam logic      SED_FLAG_RST    = 1'b0;
	localparam logic [2:0] SED_PTR_RST    = 3'h0;

	// ------------------------------------------------------------
	// status word field positions
	// ------------------------------------------------------------
	localparam int SED_ST_OVERRUN  = 0;
	localparam int SED_ST_PARITY   = 1;
	localparam int SED_ST_MODEF    = 2;
	localparam int SED_ST_RX_FULL  = 3;
	localparam int SED_ST_TX_EMPTY = 4;

	// error flags, written and read as one group
	typedef struct packed {
		logic mode_fault_flag;
		logic parity_error_flag;
		logic overrun_flag;
	} sed_flags_t;

	// serial_status_reg image
	typedef struct packed {
		logic       tx_empty;
		logic       rx_full;
		sed_flags_t flags;
	} sed_status_t;

	// static configuration bits of main_control_reg / second_control_reg
	typedef struct packed {
		logic master_select;
		logic clock_sync_select;
		logic mode_fault_enable;
		logic transmit_only_select;
		logic parity_enable;
		logic parity_odd;
	} sed_ctrl_t;

	// select_polarity_reg: bit 0 is select_zero_polarity
	typedef logic [3:0] sed_pol_t;

	typedef enum logic [0:0] {
		SED_IDLE,
		SED_SHIFT
	} sed_link_state_t;

endpackage

// ---- logic/sed_serial_periph_unit.sv ----
`timescale 1ns/1ps

module sed_serial_periph_unit
	import sed_pkg::*;
#(
	parameter int DATA_W = sed_pkg::SED_DATA_W
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	input  wire logic                  link_clk,
	input  wire sed_pkg::sed_ctrl_t    ctrl,
	input  wire sed_pkg::sed_pol_t     select_polarity_reg,
	input  wire logic [2:0]            sel_pattern,
	input  wire logic [2:0]            command_pointer,
	input  wire logic                  enable_wr,
	input  wire logic                  enable_wdata,
	output logic                       function_enable,
	input  wire logic                  data_wr,
	input  wire logic [DATA_W-1:0]     data_wdata,
	input  wire logic                  data_rd,
	output logic      [DATA_W-1:0]     data_buffer_reg,
	input  wire logic                  status_rd,
	input  wire logic                  status_wr,
	input  wire sed_pkg::sed_flags_t   status_wdata,
	output sed_pkg::sed_status_t       serial_status_reg,
	output logic      [2:0]            error_command_pointer,
	output logic                       rx_full_pulse,
	output logic                       tx_empty,
	output logic                       error_request,
	input  wire logic                  select_zero_input,
	input  wire logic                  master_in_pin_i,
	output logic                       master_in_pin_o,
	output logic                       master_in_pin_oe,
	input  wire logic                  master_out_pin_i,
	output logic                       master_out_pin_o,
	output logic                       master_out_pin_oe,
	output logic                       serial_clock_pin_oe,
	output logic      [2:0]            select_out_o,
	output logic                       select_out_oe
);
	import sed_pkg::*;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	sed_flags_t        flags_reg;
	sed_flags_t        armed_reg;
	logic [DATA_W-1:0] rx_buf_reg;
	logic [DATA_W-1:0] tx_buf_reg;
	logic [DATA_W-1:0] tx_hold_reg;
	logic              rx_full_reg;
	logic              tx_full_reg;
	logic              shift_full_reg;
	logic              load_tog_reg;
	logic              done_seen_reg;
	logic [1:0]        ref_sync;
	logic              sel_ref_sync;
	logic              done_pulse;
	logic              busy_ref;
	logic              sel_act_ref;
	logic              multi_master;
	logic              mm_fault;
	logic              sl_fault;
	logic              any_fault;
	logic              rx_parity_bad;
	logic              ovr_set;
	logic              par_set;

	// link domain
	sed_link_state_t   state_reg;
	logic [DATA_W-1:0] rx_sh_reg;
	logic [DATA_W-1:0] tx_sh_reg;
	logic [DATA_W-1:0] rx_word_reg;
	logic [$clog2(DATA_W)-1:0] cnt_reg;
	logic              done_tog_reg;
	logic              consumed_reg;
	logic              taken_tog_reg;
	logic              busy_reg;
	logic [2:0]        link_sync;
	logic              sel_link_sync;
	logic              rst_link;
	logic              en_l;
	logic              master_l;
	logic              pending_l;
	logic              sel_act_l;
	logic              start_l;
	logic              din;

	// ------------------------------------------------------------
	// crossings
	// ------------------------------------------------------------
	// done toggle and busy level into ref_clk; word is stable after the toggle
	sed_sync #(.W(2)) u_sync_ref (
		.clk (ref_clk),
		.d   ({done_tog_reg, busy_reg}),
		.q   (ref_sync)
	);

	sed_sync #(.W(1)) u_sync_sel_ref (
		.clk (ref_clk),
		.d   (select_zero_input),
		.q   (sel_ref_sync)
	);

	// enable, mode and load toggle into link_clk; hold word stays put until done
	sed_sync #(.W(3)) u_sync_link (
		.clk (link_clk),
		.d   ({function_enable, ctrl.master_select, load_tog_reg}),
		.q   (link_sync)
	);

	sed_sync #(.W(1)) u_sync_sel_link (
		.clk (link_clk),
		.d   (select_zero_input),
		.q   (sel_link_sync)
	);

	sed_sync #(.W(1)) u_sync_rst (
		.clk (link_clk),
		.d   (rst),
		.q   (rst_link)
	);

	// ------------------------------------------------------------
	// ref domain decode
	// ------------------------------------------------------------
	assign done_pulse    = ref_sync[1] ^ done_seen_reg;
	assign busy_ref      = ref_sync[0];
	assign sel_act_ref   = (sel_ref_sync == select_polarity_reg[0]);
	assign multi_master  = ctrl.master_select & ~ctrl.clock_sync_select
		& ctrl.mode_fault_enable;
	assign mm_fault      = function_enable & multi_master & sel_act_ref;
	// busy only rises once select is active, so a negation while busy is mid-frame
	assign sl_fault      = function_enable & ~ctrl.master_select
		& ~ctrl.clock_sync_select & ctrl.mode_fault_enable
		& busy_ref & ~sel_act_ref;
	assign any_fault     = mm_fault | sl_fault;
	assign rx_parity_bad = (^rx_word_reg) ^ ctrl.parity_odd;
	// overrun decided only while the flag is clear, so repeats change nothing
	assign ovr_set       = done_pulse & rx_full_reg & ~flags_reg.overrun_flag;
	assign par_set       = done_pulse & ~rx_full_reg & ~flags_reg.overrun_flag
		& ~ctrl.transmit_only_select & ctrl.parity_enable
		& rx_parity_bad;

	// done edge tracking
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			done_seen_reg <= 1'b0;
		end else begin
			done_seen_reg <= ref_sync[1];
		end
	end

	// ------------------------------------------------------------
	// enable bit
	// ------------------------------------------------------------
	// fault clears it; a set request loses while the fault flag stands
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			function_enable <= SED_EN_RST;
		end else if (any_fault) begin
			function_enable <= 1'b0;
		end else if (enable_wr) begin
			function_enable <= enable_wdata
				& ~flags_reg.mode_fault_flag;
		end
	end

	// ------------------------------------------------------------
	// error flags
	// ------------------------------------------------------------
	// arm on a status read that sees a 1; clear on a 0 written while armed.
	// a set in the same cycle wins. disabling the unit never touches them.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			flags_reg <= '{default: SED_FLAG_RST};
			armed_reg <= '{default: SED_FLAG_RST};
		end else begin
			if (status_wr) begin
				if (armed_reg.overrun_flag && !status_wdata.overrun_flag) begin
					flags_reg.overrun_flag <= 1'b0;
				end
				if (armed_reg.parity_error_flag && !status_wdata.parity_error_flag) begin
					flags_reg.parity_error_flag <= 1'b0;
				end
				if (armed_reg.mode_fault_flag && !status_wdata.mode_fault_flag) begin
					flags_reg.mode_fault_flag <= 1'b0;
				end
				armed_reg <= '{default: 1'b0};
			end else if (status_rd) begin
				armed_reg <= armed_reg | flags_reg;
			end
			if (ovr_set) begin
				flags_reg.overrun_flag <= 1'b1;
			end
			if (par_set) begin
				flags_reg.parity_error_flag <= 1'b1;
			end
			if (any_fault) begin
				flags_reg.mode_fault_flag <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// error command pointer
	// ------------------------------------------------------------
	// master mode only; slave faults leave it as it was
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			error_command_pointer <= SED_PTR_RST;
		end else if (ctrl.master_select && (ovr_set || par_set || mm_fault)) begin
			error_command_pointer <= command_pointer;
		end
	end

	// ------------------------------------------------------------
	// receive buffer
	// ------------------------------------------------------------
	// copy only when empty, no overrun and full duplex
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_buf_reg    <= '0;
			rx_full_reg   <= 1'b0;
			rx_full_pulse <= 1'b0;
		end else begin
			rx_full_pulse <= 1'b0;
			if (data_rd) begin
				rx_full_reg <= 1'b0;
			end
			if (done_pulse && !rx_full_reg && !flags_reg.overrun_flag
				&& !ctrl.transmit_only_select) begin
				rx_buf_reg    <= rx_word_reg;
				rx_full_reg   <= 1'b1;
				rx_full_pulse <= 1'b1;
			end
		end
	end

	// read always shows the buffer, empty or kept after an overrun
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			data_buffer_reg <= '0;
		end else if (data_rd) begin
			data_buffer_reg <= rx_buf_reg;
		end
	end

	// ------------------------------------------------------------
	// transmit buffer and shift register status
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tx_buf_reg     <= '0;
			tx_full_reg    <= 1'b0;
			tx_hold_reg    <= '0;
			shift_full_reg <= 1'b0;
			load_tog_reg   <= 1'b0;
		end else if (!function_enable) begin
			// disabling empties the transmit side only
			tx_full_reg    <= 1'b0;
			shift_full_reg <= 1'b0;
		end else begin
			if (done_pulse && consumed_reg) begin
				shift_full_reg <= 1'b0;
			end
			if (tx_full_reg && !shift_full_reg) begin
				tx_hold_reg    <= tx_buf_reg;
				tx_full_reg    <= 1'b0;
				shift_full_reg <= 1'b1;
				load_tog_reg   <= ~load_tog_reg;
			end
			if (data_wr && (!tx_full_reg || !shift_full_reg)) begin
				tx_buf_reg  <= data_wdata;
				tx_full_reg <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// status image, error request and pin enables
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			serial_status_reg <= '0;
		end else if (status_rd) begin
			serial_status_reg <= '{tx_empty: ~tx_full_reg, rx_full: rx_full_reg,
				flags: flags_reg};
		end
	end

	assign tx_empty      = function_enable & ~tx_full_reg;
	assign error_request = |flags_reg;

	// drivers drop together with the enable on a fault, and the cycle after it falls otherwise
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			serial_clock_pin_oe <= 1'b0;
			master_out_pin_oe   <= 1'b0;
			select_out_oe       <= 1'b0;
			master_in_pin_oe    <= 1'b0;
		end else begin
			serial_clock_pin_oe <= function_enable & ~any_fault
				& ctrl.master_select;
			master_out_pin_oe   <= function_enable & ~any_fault
				& ctrl.master_select;
			select_out_oe       <= function_enable & ~any_fault
				& ctrl.master_select;
			master_in_pin_oe    <= function_enable & ~any_fault
				& ~ctrl.master_select & sel_act_ref;
		end
	end

	// ------------------------------------------------------------
	// link side shift engine
	// ------------------------------------------------------------
	assign en_l      = link_sync[2];
	assign master_l  = link_sync[1];
	assign pending_l = link_sync[0] ^ taken_tog_reg;
	assign sel_act_l = (sel_link_sync == select_polarity_reg[0]);
	assign din       = master_l ? master_in_pin_i : master_out_pin_i;
	assign start_l   = (state_reg == SED_IDLE) && en_l && (master_l ? pending_l : sel_act_l);

	// a lost enable or a dropped slave select aborts without a done event
	always_ff @(posedge link_clk) begin
		if (rst_link) begin
			state_reg     <= SED_IDLE;
			cnt_reg       <= '0;
			busy_reg      <= 1'b0;
			taken_tog_reg <= 1'b0;
			consumed_reg  <= 1'b0;
			done_tog_reg  <= 1'b0;
			rx_sh_reg     <= '0;
			tx_sh_reg     <= '0;
			rx_word_reg   <= '0;
		end else begin
			case (state_reg)
				SED_IDLE: begin
					if (start_l) begin
						state_reg    <= SED_SHIFT;
						busy_reg     <= 1'b1;
						cnt_reg      <= '0;
						consumed_reg <= pending_l;
						if (pending_l) begin
							tx_sh_reg     <= tx_hold_reg;
							taken_tog_reg <= link_sync[0];
						end else begin
							tx_sh_reg <= rx_word_reg;
						end
					end
				end
				SED_SHIFT: begin
					if (!en_l || (!master_l && !sel_act_l)) begin
						state_reg <= SED_IDLE;
						busy_reg  <= 1'b0;
					end else begin
						rx_sh_reg <= {rx_sh_reg[DATA_W-2:0], din};
						tx_sh_reg <= {tx_sh_reg[DATA_W-2:0], 1'b0};
						cnt_reg   <= cnt_reg + 1'b1;
						if (cnt_reg == ($clog2(DATA_W))'(DATA_W - 1)) begin
							rx_word_reg  <= {rx_sh_reg[DATA_W-2:0], din};
							done_tog_reg <= ~done_tog_reg;
							state_reg    <= SED_IDLE;
							busy_reg     <= 1'b0;
						end
					end
				end
				default: begin
					state_reg <= SED_IDLE;
				end
			endcase
		end
	end

	// data and select levels at the pins, msb first
	always_ff @(posedge link_clk) begin
		if (rst_link) begin
			master_out_pin_o <= 1'b0;
			master_in_pin_o  <= 1'b0;
			select_out_o     <= ~select_polarity_reg[3:1];
		end else begin
			master_out_pin_o <= tx_sh_reg[DATA_W-1];
			master_in_pin_o  <= tx_sh_reg[DATA_W-1];
			// asserted on the start edge, so the far side has its first bit up in time
			select_out_o     <= (busy_reg || start_l)
				? (sel_pattern ~^ select_polarity_reg[3:1]) : ~select_polarity_reg[3:1];
		end
	end

endmodule // sed_serial_periph_unit

// ---- logic/sed_sync.sv ----
`timescale 1ns/1ps

// ------------------------------------------------------------
// two-flop level synchroniser
// ------------------------------------------------------------
module sed_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		meta_reg <= d;
		q        <= meta_reg;
	end
endmodule // sed_sync

// ---- verif/sed_far_end.sv ----
`timescale 1ns/1ps

module sed_far_end #(
	parameter int W = 8
) (
	input  wire logic         link_clk,
	input  wire logic         dev_select,
	input  wire logic         dev_sel_level,
	input  wire logic [W-1:0] reply_word,
	input  wire logic         sel_level,
	input  wire logic         mosi_in,
	output logic              miso,
	output logic              mosi,
	output logic              ssel
);
	int   bit_idx;
	logic in_frame;
	logic [W-1:0] heard;    // last bits seen on the device's data-out line

	initial begin
		miso = 1'b0;
		mosi = 1'b0;
		ssel = 1'b1;
		bit_idx = 0;
		in_frame = 1'b0;
	end

	// slave reply, msb first; a released line toggles so no stale level survives
	always @(negedge link_clk) begin
		if (dev_select === dev_sel_level) begin
			miso <= reply_word[W - 1 - (bit_idx % W)];
			bit_idx <= bit_idx + 1;
			heard   <= {heard[W-2:0], mosi_in};
		end else begin
			miso <= ~miso;
			bit_idx <= 0;
		end
		if (!in_frame) begin
			mosi <= ~mosi;
		end
	end

	// master frame whose select drops after hold edges, short of a word
	task automatic master_frame(input logic [W-1:0] w, input int hold);
		in_frame = 1'b1;
		@(negedge link_clk);
		ssel <= sel_level;
		for (int i = 0; i < hold; i++) begin
			mosi <= w[W - 1 - (i % W)];
			@(negedge link_clk);
		end
		ssel <= ~sel_level;
		in_frame = 1'b0;
	endtask

endmodule // sed_far_end

// ---- verif/sed_spu_assertions.sv ----
`timescale 1ns/1ps

module sed_spu_assertions #(
	parameter int DATA_W = sed_pkg::SED_DATA_W
) (
	input wire logic                 ref_clk,
	input wire logic                 rst,
	input wire sed_pkg::sed_ctrl_t   ctrl,
	input wire sed_pkg::sed_pol_t    select_polarity_reg,
	input wire logic [2:0]           command_pointer,
	input wire logic                 enable_wr,
	input wire logic                 enable_wdata,
	input wire logic                 function_enable,
	input wire logic                 data_rd,
	input wire logic [DATA_W-1:0]    data_buffer_reg,
	input wire logic                 status_rd,
	input wire logic                 status_wr,
	input wire sed_pkg::sed_status_t serial_status_reg,
	input wire logic [2:0]           error_command_pointer,
	input wire logic                 error_request,
	input wire logic                 select_zero_input,
	input wire logic                 master_in_pin_oe,
	input wire logic                 master_out_pin_oe,
	input wire logic                 serial_clock_pin_oe,
	input wire logic                 select_out_oe
);
	import sed_pkg::*;

	logic rd_seen_reg;
	logic mm_hit;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// helper logic
	// ------------------------------------------------------------
	// any flag write disarms, so a clear needs a fresh status read
	always_ff @(posedge ref_clk) begin
		if (rst || status_wr) begin
			rd_seen_reg <= 1'b0;
		end else if (status_rd) begin
			rd_seen_reg <= 1'b1;
		end
	end

	// multi-master, enabled, select zero at its active level
	assign mm_hit = ctrl.master_select && !ctrl.clock_sync_select && ctrl.mode_fault_enable
		&& function_enable && (select_zero_input == select_polarity_reg[0]);

	sequence s_mm_held;
		mm_hit [*3];
	endsequence

	sequence s_mf_seen;
		status_rd ##1 serial_status_reg.flags.mode_fault_flag;
	endsequence

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	a_mm_fault_raise: assert property (s_mm_held |-> ##[0:2] error_request)
		else $error("select zero active in multi-master without fault");
	a_fault_release: assert property (s_mf_seen |-> !function_enable && !serial_clock_pin_oe
		&& !master_out_pin_oe && !select_out_oe && !master_in_pin_oe)
		else $error("mode fault left function or drivers on");
	a_enable_refused: assert property (enable_wr && enable_wdata |=> function_enable || error_request)
		else $error("enable write lost without a flag set");
	a_err_req_or: assert property (status_rd |=> (|serial_status_reg.flags) == $past(error_request))
		else $error("error request differs from flags");
	a_disable_keeps: assert property (enable_wr && !enable_wdata && !status_wr
		|=> $stable(error_command_pointer) && (error_request || !$past(error_request)))
		else $error("disable changed flags or pointer");
	a_ptr_capture: assert property ($rose(error_request) && ctrl.master_select
		|-> error_command_pointer == $past(command_pointer))
		else $error("pointer not captured on error");
	a_flag_clear: assert property ($fell(error_request) |-> $past(status_wr) && $past(rd_seen_reg))
		else $error("flag cleared without read then write");
	a_oe_follow: assert property (!function_enable ##1 !function_enable
		|-> !(serial_clock_pin_oe || master_out_pin_oe || select_out_oe || master_in_pin_oe))
		else $error("pin driven while disabled");
	a_rx_word_hold: assert property ($changed(data_buffer_reg) |-> $past(data_rd) || $past(data_rd, 2))
		else $error("read word changed without a read");

endmodule // sed_spu_assertions

bind sed_serial_periph_unit sed_spu_assertions #(.DATA_W(DATA_W)) u_chk (
	.ref_clk(ref_clk), .rst(rst), .ctrl(ctrl), .select_polarity_reg(select_polarity_reg),
	.command_pointer(command_pointer), .enable_wr(enable_wr), .enable_wdata(enable_wdata),
	.function_enable(function_enable), .data_rd(data_rd), .data_buffer_reg(data_buffer_reg),
	.status_rd(status_rd), .status_wr(status_wr), .serial_status_reg(serial_status_reg),
	.error_command_pointer(error_command_pointer), .error_request(error_request),
	.select_zero_input(select_zero_input), .master_in_pin_oe(master_in_pin_oe),
	.master_out_pin_oe(master_out_pin_oe), .serial_clock_pin_oe(serial_clock_pin_oe),
	.select_out_oe(select_out_oe)
);

// ---- verif/test_spi_error_detection.sv ----
`timescale 1ns/1ps

module test_spi_error_detection;
	import sed_pkg::*;

	logic                  ref_clk, link_clk, rst, enable_wr, enable_wdata, data_wr, data_rd;
	logic                  status_rd, status_wr, function_enable, rx_full_pulse, tx_empty;
	logic                  error_request, sel0_in, miso_o, miso_oe, mosi_o, mosi_oe, sck_oe;
	logic                  sel_oe, far_miso, far_mosi, miso_line, mosi_line;
	logic [SED_DATA_W-1:0] data_wdata, data_buffer_reg, reply;
	logic [2:0]            sel_pattern, command_pointer, error_command_pointer, select_out_o;
	sed_ctrl_t             ctrl;
	sed_pol_t              select_polarity_reg;
	sed_flags_t            status_wdata;
	sed_status_t           serial_status_reg;
	int                    mismatches, cmp_count, rx_pulses, seen;

	// shared data lines resolved from the device's enables only; the far end drives them otherwise
	assign miso_line = miso_oe ? miso_o : far_miso;
	assign mosi_line = mosi_oe ? mosi_o : far_mosi;

	sed_serial_periph_unit #(.DATA_W(SED_DATA_W)) DUT (
		.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .ctrl(ctrl),
		.select_polarity_reg(select_polarity_reg), .sel_pattern(sel_pattern),
		.command_pointer(command_pointer), .enable_wr(enable_wr), .enable_wdata(enable_wdata),
		.function_enable(function_enable), .data_wr(data_wr), .data_wdata(data_wdata),
		.data_rd(data_rd), .data_buffer_reg(data_buffer_reg), .status_rd(status_rd),
		.status_wr(status_wr), .status_wdata(status_wdata), .serial_status_reg(serial_status_reg),
		.error_command_pointer(error_command_pointer), .rx_full_pulse(rx_full_pulse),
		.tx_empty(tx_empty), .error_request(error_request), .select_zero_input(sel0_in),
		.master_in_pin_i(miso_line), .master_in_pin_o(miso_o), .master_in_pin_oe(miso_oe),
		.master_out_pin_i(mosi_line), .master_out_pin_o(mosi_o), .master_out_pin_oe(mosi_oe),
		.serial_clock_pin_oe(sck_oe), .select_out_o(select_out_o), .select_out_oe(sel_oe)
	);

	sed_far_end #(.W(SED_DATA_W)) far (
		.link_clk(link_clk), .dev_select(select_out_o[0]), .dev_sel_level(select_polarity_reg[1]),
		.reply_word(reply), .sel_level(select_polarity_reg[0]), .miso(far_miso),
		.mosi(far_mosi), .ssel(sel0_in), .mosi_in(mosi_line)
	);

	// ------------------------------------------------------------
	// clocks, pulse count, watchdog
	// ------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// bit clock runs free: the design starts master frames from it
	initial begin
		link_clk = 1'b0;
		#7;
		forever #24 link_clk = ~link_clk;
	end
	always @(posedge ref_clk) begin
		if (rx_full_pulse === 1'b1) begin
			rx_pulses++;
		end
	end
	initial begin
		#200000;
		mismatches++;
		test_done();
	end

	// ------------------------------------------------------------
	// compare and access tasks
	// ------------------------------------------------------------
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic miss(input string what);
		mismatches++;
		$display("mismatch at %0t: %s", $time, what);
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string what);
		cmp_count++;
		if (got !== exp) miss(what);
	endtask
	task automatic chk_word(input logic [SED_DATA_W-1:0] got, input logic [SED_DATA_W-1:0] exp);
		cmp_count++;
		if (got !== exp) miss("read word");
	endtask
	task automatic chk_ptr(input logic [2:0] exp);
		cmp_count++;
		if (error_command_pointer !== exp) miss("error pointer");
	endtask
	task automatic chk_flags(input sed_flags_t got, input sed_flags_t exp);
		cmp_count++;
		if (got !== exp) miss("flags");
	endtask
	// strobes rise after one edge and drop after the next
	task automatic strobe(input int which, input logic [SED_DATA_W-1:0] d);
		@(posedge ref_clk);
		enable_wr <= (which == 0);
		data_wr <= (which == 1);
		data_rd <= (which == 2);
		status_rd <= (which == 3);
		status_wr <= (which == 4);
		enable_wdata <= d[0];
		data_wdata <= d;
		status_wdata <= d[2:0];
		@(posedge ref_clk);
		{enable_wr, data_wr, data_rd, status_rd, status_wr} <= 5'h00;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic read_data(input logic [SED_DATA_W-1:0] exp);
		strobe(2, 8'h00);
		chk_word(data_buffer_reg, exp);
	endtask
	task automatic read_status(input sed_flags_t exp);
		strobe(3, 8'h00);
		chk_flags(serial_status_reg.flags, exp);
	endtask
	// bounded wait: 0 receive pulse, 1 error request, 2 transmit empty
	task automatic wait_for(input int which);
		int n;
		n = 0;
		while (n < 400 && (which == 0 ? rx_full_pulse : which == 1 ? error_request : tx_empty) !== 1'b1) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk_bit(n < 400, 1'b1, "wait ran out");
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{rst, enable_wr, enable_wdata, data_wr, data_rd, status_rd, status_wr} = 7'h40;
		{mismatches, cmp_count, rx_pulses} = '0;
		ctrl = 6'h22;
		select_polarity_reg = 4'h0;
		sel_pattern = 3'h1;
		command_pointer = 3'h5;
		data_wdata = 8'h00;
		status_wdata = 3'h0;
		reply = 8'hff;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (3) @(posedge link_clk);
		chk_bit(error_request, 1'b0, "reset error request");
		chk_ptr(3'h0);
		strobe(0, 8'h01);
		chk_bit(function_enable, 1'b1, "enable");
		strobe(1, 8'h3c);
		wait_for(0);
		chk_word(far.heard, 8'h3c);
		read_data(8'hff);
		read_data(8'hff);
		chk_bit(error_request, 1'b0, "empty read flagged");
		reply <= 8'h00;
		strobe(1, 8'h5a);
		wait_for(0);
		reply <= 8'hff;
		strobe(1, 8'ha5);
		wait_for(1);
		chk_ptr(3'h5);
		read_data(8'h00);
		strobe(4, 8'h00);
		read_status(3'h1);
		chk_bit(serial_status_reg.tx_empty & ~serial_status_reg.rx_full, 1'b1, "buffer status");
		command_pointer <= 3'h6;
		ctrl.parity_odd <= 1'b1;
		seen = rx_pulses;
		strobe(1, 8'h11);
		strobe(1, 8'h22);
		chk_bit(tx_empty, 1'b0, "second word held");
		wait_for(2);
		repeat (120) @(posedge ref_clk);
		chk_bit(rx_pulses == seen, 1'b1, "pulse during overrun");
		chk_ptr(3'h5);
		read_data(8'h00);
		strobe(0, 8'h00);
		read_status(3'h1);
		chk_ptr(3'h5);
		strobe(4, 8'h00);
		read_status(3'h0);
		strobe(0, 8'h01);
		command_pointer <= 3'h2;
		strobe(1, 8'h33);
		wait_for(1);
		chk_ptr(3'h2);
		read_data(8'hff);
		read_status(3'h2);
		strobe(4, 8'h00);
		read_status(3'h0);
		ctrl.parity_odd <= 1'b0;
		ctrl.mode_fault_enable <= 1'b1;
		command_pointer <= 3'h7;
		repeat (20) @(posedge ref_clk);
		chk_bit(error_request, 1'b0, "inactive select faulted");
		select_polarity_reg[0] <= 1'b1;
		wait_for(1);
		repeat (3) @(posedge ref_clk);
		chk_bit(function_enable, 1'b0, "fault left enable");
		chk_bit(sck_oe | mosi_oe | sel_oe, 1'b0, "master pins driven");
		chk_ptr(3'h7);
		strobe(0, 8'h01);
		chk_bit(function_enable, 1'b0, "enable taken in fault");
		select_polarity_reg[0] <= 1'b0;
		read_status(3'h4);
		strobe(4, 8'h00);
		read_status(3'h0);
		strobe(0, 8'h01);
		chk_bit(function_enable, 1'b1, "enable after clear");
		command_pointer <= 3'h3;
		far.master_frame(8'h00, 6);
		wait_for(1);
		chk_bit(function_enable, 1'b0, "pin fault left enable");
		chk_ptr(3'h3);
		read_status(3'h4);
		strobe(4, 8'h00);
		read_status(3'h0);
		strobe(0, 8'h00);
		ctrl.master_select <= 1'b0;
		strobe(0, 8'h01);
		far.master_frame(8'hff, 6);
		wait_for(1);
		repeat (3) @(posedge ref_clk);
		chk_bit(function_enable, 1'b0, "slave fault left enable");
		chk_bit(miso_oe, 1'b0, "slave output driven");
		test_done();
	end

endmodule // test_spi_error_detection
